// ==== rtl/hex_record_loader.sv ====
// Hex record loader: decodes ASCII data and end records, writes memory.
// Assumes characters come one per valid pulse from logic on core_clk,
// and that the memory write port takes one byte on any cycle.
// Restart keeps the entry address; only reset clears it.
`timescale 1ns/1ps
`default_nettype none
module hex_record_loader
   import hex_loader_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Character stream in
   input wire logic char_valid,
   input wire logic [7:0] char_data,
   // Start over after done or error
   input wire logic restart,
   // Memory write port
   output logic mem_wr_en,
   output logic [15:0] mem_wr_addr,
   output logic [7:0] mem_wr_data,
   // Status
   output logic loading,
   output logic load_done,
   output logic load_error,
   output logic [15:0] entry_addr
);

   loader_s st_reg;
   loader_s st_next;

   logic [3:0] nib;
   logic nib_ok;
   logic [7:0] sum_reg;
   logic sum_clr;
   logic sum_add;
   logic [7:0] full_byte;
   logic byte_done;
   logic at_cksum;
   // Field position and error causes
   logic at_len;
   logic at_addr_hi;
   logic at_addr_lo;
   logic bad_digit;
   logic bad_type;
   logic bad_len;
   logic bad_sum;
   logic fail_now;
   logic [15:0] addr_inc;
   // Character classes
   logic ch_start;
   logic ch_data_type;
   logic ch_end_type;
   logic ch_eol;

   hex_digit_decode u_digit (
      .ascii(char_data),
      .nibble(nib),
      .is_hex(nib_ok)
   );

   record_sum #(
      .WIDTH(8)
   ) u_sum (
      .core_clk(core_clk),
      .rst(rst),
      .sum_clr(sum_clr),
      .sum_add(sum_add),
      .add_byte(full_byte),
      .sum_reg(sum_reg)
   );

   // high nibble held, low nibble joins it
   assign full_byte = {st_reg.hi_nib, nib};
   assign byte_done = char_valid && nib_ok && st_reg.lo_phase
      && (st_reg.state == ST_FIELD);
   assign at_cksum = (st_reg.pair_idx != IDX_LEN)
      && (st_reg.pair_idx == {1'b0, st_reg.rec_len});

   // Position of the pair that the current low nibble completes
   always_comb begin
      at_len = (st_reg.pair_idx == IDX_LEN);
      at_addr_hi = (st_reg.pair_idx == IDX_ADDR_HI);
      at_addr_lo = (st_reg.pair_idx == IDX_ADDR_LO);
   end

   // pointer steps one byte; wraps at the top of memory
   assign addr_inc = 16'(st_reg.addr_ptr + 16'h0001);

   // error causes, one net each so a trace shows which fired
   always_comb begin
      bad_digit = 1'b0;
      bad_type = 1'b0;
      bad_len = 1'b0;
      bad_sum = 1'b0;
      if (char_valid && st_reg.state == ST_TYPE) begin
         // once loading, only data or end types
         bad_type = st_reg.started && !ch_data_type && !ch_end_type;
      end
      if (char_valid && st_reg.state == ST_FIELD) begin
         // Line ends inside a field count as bad digits
         bad_digit = !nib_ok;
      end
      if (byte_done && at_len) begin
         // length too short, or end record not three pairs
         bad_len = (full_byte < LEN_MIN) || (st_reg.is_end && full_byte != LEN_END);
      end
      if (byte_done && at_cksum) begin
         bad_sum = full_byte != ~sum_reg;
      end
      fail_now = bad_digit || bad_type || bad_len || bad_sum;
   end

   // Character classes shared by several states
   always_comb begin
      ch_start = char_valid && (char_data == CHAR_REC_START);
      ch_data_type = char_valid && (char_data == CHAR_TYPE_DATA);
      ch_end_type = char_valid && (char_data == CHAR_TYPE_END);
      ch_eol = char_valid && is_eol(char_data);
   end

   // Sum cleared on the type digit, ahead of the length pair
   always_comb begin
      sum_clr = (st_reg.state == ST_TYPE) && char_valid;
      // length, address and data summed, checksum not
      sum_add = byte_done && !at_cksum;
   end

   always_comb begin
      st_next = st_reg;
      st_next.wr_en = 1'b0;
      unique case (st_reg.state)
         ST_HUNT: begin
            // anything but the start letter is dropped
            if (ch_start) begin
               st_next.state = ST_TYPE;
            end
         end
         ST_TYPE: begin
            if (char_valid) begin
               st_next.lo_phase = 1'b0;
               st_next.pair_idx = IDX_LEN;
               if (ch_data_type) begin
                  st_next.is_end = 1'b0;
                  st_next.state = ST_FIELD;
               end else if (ch_end_type && st_reg.started) begin
                  st_next.is_end = 1'b1;
                  st_next.state = ST_FIELD;
               end else if (bad_type) begin
                  // only data or end once loading
                  st_next.error = 1'b1;
                  st_next.state = ST_ERR;
               end else begin
                  st_next.state = ST_SKIP;
               end
            end
         end
         ST_FIELD: begin
            if (bad_digit) begin
               // a non-hex character inside a field
               st_next.error = 1'b1;
               st_next.state = ST_ERR;
            end else if (char_valid && !st_reg.lo_phase) begin
               st_next.hi_nib = nib;
               st_next.lo_phase = 1'b1;
            end else if (byte_done) begin
               st_next.lo_phase = 1'b0;
               st_next.pair_idx = 9'(st_reg.pair_idx + 9'h001);
               if (at_len) begin
                  // length must cover address and checksum
                  st_next.rec_len = full_byte;
                  if (bad_len) begin
                     st_next.error = 1'b1;
                     st_next.state = ST_ERR;
                  end
               end else if (at_addr_hi) begin
                  st_next.addr_ptr = {full_byte, BYTE_RST};
               end else if (at_addr_lo) begin
                  st_next.addr_ptr = {st_reg.addr_ptr[15:8], full_byte};
               end else if (at_cksum) begin
                  if (bad_sum) begin
                     st_next.error = 1'b1;
                     st_next.state = ST_ERR;
                  end else if (st_reg.is_end) begin
                     // entry address captured at the end
                     st_next.entry_addr = st_reg.addr_ptr;
                     st_next.done = 1'b1;
                     st_next.started = 1'b0;
                     st_next.state = ST_DONE;
                  end else begin
                     // loading has begun with a good data record
                     st_next.started = 1'b1;
                     st_next.state = ST_HUNT;
                  end
               end else begin
                  // each data byte to the next address
                  st_next.wr_en = 1'b1;
                  st_next.wr_addr = st_reg.addr_ptr;
                  st_next.wr_data = full_byte;
                  // Written at once, before the checksum is known
                  st_next.addr_ptr = addr_inc;
               end
            end else if (char_valid) begin
               st_next.state = ST_FIELD;
            end
         end
         ST_SKIP: begin
            // line end closes an ignored record
            // Skipped records are not checked, so a bad header is harmless
            if (ch_eol) begin
               st_next.state = ST_HUNT;
            end
         end
         ST_DONE: begin
            // Later records ignored until restart
            st_next.state = ST_DONE;
         end
         ST_ERR: begin
            st_next.state = ST_ERR;
         end
      endcase
      // a failed record drops loading; a later end cannot complete it
      if (fail_now) begin
         st_next.started = 1'b0;
      end
      // Restart wins over a same-cycle character in state, flags and write strobe
      if (restart) begin
         st_next.state = ST_HUNT;
         st_next.started = 1'b0;
         st_next.done = 1'b0;
         st_next.error = 1'b0;
         st_next.wr_en = 1'b0;
         st_next.lo_phase = 1'b0;
         st_next.pair_idx = IDX_LEN;
         st_next.is_end = 1'b0;
         // Entry address kept so it can still be read after a restart
      end
   end

   // Every field reset on its own so no flop starts unknown
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg.state <= ST_HUNT;
         st_reg.started <= 1'b0;
         st_reg.lo_phase <= 1'b0;
         st_reg.hi_nib <= NIB_RST;
         st_reg.rec_len <= BYTE_RST;
         st_reg.pair_idx <= IDX_LEN;
         st_reg.is_end <= 1'b0;
         st_reg.addr_ptr <= ADDR_RST;
         st_reg.wr_en <= 1'b0;
         st_reg.wr_addr <= ADDR_RST;
         st_reg.wr_data <= BYTE_RST;
         st_reg.done <= 1'b0;
         st_reg.error <= 1'b0;
         st_reg.entry_addr <= ADDR_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state flops
   assign mem_wr_en = st_reg.wr_en;
   assign mem_wr_addr = st_reg.wr_addr;
   assign mem_wr_data = st_reg.wr_data;
   assign loading = st_reg.started;
   assign load_done = st_reg.done;
   assign load_error = st_reg.error;
   assign entry_addr = st_reg.entry_addr;

endmodule : hex_record_loader
`default_nettype wire

// ==== rtl/hex_loader_pkg.sv ====
// Shared constants, states and state record of the hex record loader.
// Assumes 8-bit ASCII characters arrive already framed on the core clock.
package hex_loader_pkg;

   // Character codes
   localparam logic [7:0] CHAR_REC_START = 8'h53;
   localparam logic [7:0] CHAR_TYPE_DATA = 8'h31;
   localparam logic [7:0] CHAR_TYPE_END = 8'h39;
   localparam logic [7:0] CHAR_CR = 8'h0D;
   localparam logic [7:0] CHAR_LF = 8'h0A;
   localparam logic [7:0] CHAR_NUL = 8'h00;

   // Field positions, counted in byte pairs after the type field
   localparam logic [8:0] IDX_LEN = 9'h000;
   localparam logic [8:0] IDX_ADDR_HI = 9'h001;
   localparam logic [8:0] IDX_ADDR_LO = 9'h002;
   localparam logic [8:0] IDX_DATA = 9'h003;

   // Length limits: address plus checksum is the least a record holds
   localparam logic [7:0] LEN_MIN = 8'h03;
   localparam logic [7:0] LEN_END = 8'h03;

   // Reset values
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [3:0] NIB_RST = 4'h0;

   typedef enum logic [2:0] {
      ST_HUNT,
      ST_TYPE,
      ST_FIELD,
      ST_SKIP,
      ST_DONE,
      ST_ERR
   } load_state_e;

   typedef struct packed {
      load_state_e state;
      logic started;
      logic lo_phase;
      logic [3:0] hi_nib;
      logic [7:0] rec_len;
      logic [8:0] pair_idx;
      logic is_end;
      logic [15:0] addr_ptr;
      logic wr_en;
      logic [15:0] wr_addr;
      logic [7:0] wr_data;
      logic done;
      logic error;
      logic [15:0] entry_addr;
   } loader_s;

   // Line end characters between records
   function automatic logic is_eol(input logic [7:0] c);
      is_eol = (c == CHAR_CR) || (c == CHAR_LF) || (c == CHAR_NUL);
   endfunction : is_eol

endpackage : hex_loader_pkg

// ==== rtl/hex_digit_decode.sv ====
// ASCII hexadecimal digit to nibble decoder, purely combinational.
// Assumes the caller samples the result on its own clock.
`timescale 1ns/1ps
`default_nettype none
module hex_digit_decode (
   // Character in
   input wire logic [7:0] ascii,
   // Decoded value
   output logic [3:0] nibble,
   output logic is_hex
);

   always_comb begin
      nibble = 4'h0;
      is_hex = 1'b1;
      if (ascii >= 8'h30 && ascii <= 8'h39) begin
         nibble = 4'(ascii - 8'h30);
      end else if (ascii >= 8'h41 && ascii <= 8'h46) begin
         nibble = 4'(ascii - 8'h37);
      end else if (ascii >= 8'h61 && ascii <= 8'h66) begin
         // Lower case accepted too; hosts differ
         nibble = 4'(ascii - 8'h57);
      end else begin
         is_hex = 1'b0;
      end
   end

endmodule : hex_digit_decode
`default_nettype wire

// ==== rtl/record_sum.sv ====
// Running modulo-256 sum of the bytes of one record.
// Assumes clear and add are never needed in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module record_sum #(
   parameter int WIDTH = 8
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic sum_clr,
   input wire logic sum_add,
   input wire logic [WIDTH-1:0] add_byte,
   // Result
   output logic [WIDTH-1:0] sum_reg
);

   logic [WIDTH-1:0] sum_next;

   always_comb begin
      sum_next = sum_reg;
      if (sum_clr) begin
         sum_next = '0;
      end else if (sum_add) begin
         // Carries out of the top bit are dropped on purpose
         sum_next = WIDTH'(sum_reg + add_byte);
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sum_reg <= '0;
      end else begin
         sum_reg <= sum_next;
      end
   end

endmodule : record_sum
`default_nettype wire

// ==== verification/hex_loader_props.sv ====
// Port checker for the hex record loader.
// Bound to every hex_record_loader instance; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module hex_loader_props (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Inputs
   input wire logic char_valid,
   input wire logic [7:0] char_data,
   input wire logic restart,
   // Outputs
   input wire logic mem_wr_en,
   input wire logic [15:0] mem_wr_addr,
   input wire logic [7:0] mem_wr_data,
   input wire logic loading,
   input wire logic load_done,
   input wire logic load_error,
   input wire logic [15:0] entry_addr
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   a_wr_pulse: assert property (mem_wr_en |=> !mem_wr_en) else $error("write strobe too long");
   a_wr_cause: assert property (mem_wr_en |-> $past(char_valid) && !$past(restart))
      else $error("write without a character");
   a_wr_hold: assert property (!mem_wr_en |-> $stable(mem_wr_addr) && $stable(mem_wr_data))
      else $error("write port moved without a write");
   a_err_halt: assert property (load_error && !restart |=> load_error && !mem_wr_en && !loading)
      else $error("error state left or written");
   a_done_hold: assert property (load_done && !restart |=> load_done && $stable(entry_addr))
      else $error("done state not held");
   a_entry_cause: assert property (!$rose(load_done) |-> $stable(entry_addr))
      else $error("entry address moved");
   a_done_cause: assert property ($rose(load_done) |-> $past(loading) && $past(char_valid) && !loading)
      else $error("done without loading");
   a_load_cause: assert property ($rose(loading) |-> $past(char_valid) && !load_done && !load_error)
      else $error("loading rose wrongly");
   a_restart_clr: assert property (restart |=> !loading && !load_done && !load_error)
      else $error("restart did not clear flags");
   a_flag_excl: assert property (!(load_done && load_error)) else $error("done and error together");
   c_write: cover property (mem_wr_en);
   c_done: cover property ($rose(load_done));
   c_error: cover property ($rose(load_error));
endmodule : hex_loader_props
bind hex_record_loader hex_loader_props u_props (.core_clk, .rst, .char_valid, .char_data, .restart,
   .mem_wr_en, .mem_wr_addr, .mem_wr_data, .loading, .load_done, .load_error, .entry_addr);
`default_nettype wire

// ==== verification/hex_host_model.sv ====
// Host side: sends record text as ASCII characters on the character port.
// Assumes every call is made from the bench's single stimulus process.
`timescale 1ns/1ps
`default_nettype none
module hex_host_model (
   // Clock
   input wire logic core_clk,
   // Character stream
   output logic char_valid,
   output logic [7:0] char_data
);
   initial begin
      char_valid = 1'b0;
      char_data = 8'h00;
   end
   task automatic send_chr(input logic [7:0] c, input int gap);
      @(posedge core_clk);
      char_valid <= 1'b1;
      char_data <= c;
      if (gap > 0) begin
         @(posedge core_clk);
         char_valid <= 1'b0;
         // Idle line never shows a stale character
         char_data <= ~c;
         repeat (gap - 1) @(posedge core_clk);
      end
   endtask : send_chr
   task automatic send_str(input string s, input int gap);
      for (int i = 0; i < s.len(); i++) begin
         send_chr(s[i], gap);
      end
   endtask : send_str
   task automatic release_line;
      @(posedge core_clk);
      char_valid <= 1'b0;
      char_data <= ~char_data;
   endtask : release_line
endmodule : hex_host_model
`default_nettype wire

// ==== verification/test_hex_record_loader.sv ====
// Self-checking bench for the hex record loader.
// Host model drives characters; the bench drives reset and restart.
`timescale 1ns/1ps
`default_nettype none
module test_hex_record_loader;
   logic core_clk, rst, restart, char_valid, mem_wr_en, loading, load_done, load_error;
   logic [7:0] char_data, mem_wr_data;
   logic [15:0] mem_wr_addr, entry_addr;
   logic [23:0] exp_q[$], got_q[$];
   int n_mismatch = 0;
   int checks_done = 0;
   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end
   hex_record_loader DUT (.core_clk, .rst, .char_valid, .char_data, .restart, .mem_wr_en, .mem_wr_addr,
      .mem_wr_data, .loading, .load_done, .load_error, .entry_addr);
   hex_host_model host (.core_clk, .char_valid, .char_data);
   always @(posedge core_clk) if (mem_wr_en === 1'b1) got_q.push_back({mem_wr_addr, mem_wr_data});
   task automatic chk_bit(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk_word
   function automatic string mk(logic [7:0] ty, logic [15:0] a, int n, logic [7:0] d0, bit exp);
      logic [7:0] sum, b;
      string s;
      sum = n[7:0] + 8'h03 + a[15:8] + a[7:0];
      s = $sformatf("S%0d%02X%04X", ty, n + 3, a);
      for (int i = 0; i < n; i++) begin
         b = d0 + i[7:0];
         sum += b;
         s = {s, $sformatf("%02X", b)};
         if (exp) exp_q.push_back({a + i[15:0], b});
      end
      return {s, $sformatf("%02X", ~sum)};
   endfunction : mk
   task automatic line(input string s, input int gap);
      host.send_str(s, gap);
      host.send_chr(8'h0D, 0);
      host.send_chr(8'h0A, 0);
      host.release_line();
      @(negedge core_clk);
   endtask : line
   task automatic check_writes;
      chk_word(16'(got_q.size()), 16'(exp_q.size()), "write count");
      foreach (exp_q[i]) if (i < got_q.size()) begin
         chk_word(got_q[i][23:8], exp_q[i][23:8], "write address");
         chk_word({8'h00, got_q[i][7:0]}, {8'h00, exp_q[i][7:0]}, "write data");
      end
      exp_q.delete();
      got_q.delete();
   endtask : check_writes
   task automatic pulse_restart;
      @(posedge core_clk);
      restart <= 1'b1;
      @(posedge core_clk);
      restart <= 1'b0;
      @(negedge core_clk);
   endtask : pulse_restart
   task automatic t_load;
      host.send_str("12 ", 1);
      line("S00600004844521B", 0);
      line("S9030000FC", 0);
      chk_bit(loading, 1'b0, "loading before data");
      line(mk(1, 16'h0100, 4, 8'hF0, 1), 0);
      chk_bit(loading, 1'b1, "loading after data");
      host.send_chr(8'h00, 1);
      line(mk(1, 16'h2000, 0, 8'h00, 1), 2);
      line(mk(1, 16'h3000, 30, 8'h41, 1), 1);
      exp_q.push_back({16'h0200, 8'hAB});
      exp_q.push_back({16'h0201, 8'hCD});
      line("S1050200abcd80", 0);
      check_writes();
      line(mk(9, 16'h1234, 0, 8'h00, 0), 0);
      chk_bit(load_done, 1'b1, "done");
      chk_bit(loading, 1'b0, "loading after end");
      chk_word(entry_addr, 16'h1234, "entry address");
      line(mk(1, 16'h4000, 2, 8'h00, 0), 0);
      check_writes();
      $display("t_load done");
   endtask : t_load
   task automatic t_errors;
      string bad[5] = '{"S2040000AA51", "S1040010AB41", "S1040010AG40", "S1020000FD", "S9040000AA51"};
      foreach (bad[i]) begin
         pulse_restart();
         chk_bit(load_error, 1'b0, "error cleared");
         chk_bit(load_done, 1'b0, "done cleared");
         chk_word(entry_addr, 16'h1234, "entry kept");
         line(mk(1, 16'h0800, 2, 8'hC0, 1), 0);
         check_writes();
         line(bad[i], 0);
         chk_bit(load_error, 1'b1, "bad record");
         chk_bit(loading, 1'b0, "loading after error");
         got_q.delete();
         line("S9030000FC", 0);
         chk_bit(load_done, 1'b0, "end after error");
      end
      $display("t_errors done");
   endtask : t_errors
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      rst = 1'b1;
      restart = 1'b0;
      repeat (20) @(posedge core_clk);
      rst <= 1'b0;
      t_load();
      t_errors();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      give_verdict();
   end
endmodule : test_hex_record_loader
`default_nettype wire
